/* File: hdl/csv_pkg.sv */
// Shared constants of the charger status and voltage register block.
package csv_pkg;
  // Register byte addresses as seen through the serial port.
  localparam logic [7:0] ADDR_VOLT_LOW = 8'h04;
  localparam logic [7:0] ADDR_STAT_LOW = 8'h20;
  localparam logic [7:0] ADDR_STAT_HIGH = 8'h21;
  localparam logic [7:0] ADDR_HOT_STAT = 8'h22;
  localparam logic [7:0] ADDR_ASSIST_CTRL = 8'h32;
  // Charge-voltage low byte: value bits 7..3 kept, bits 2..0 reserved.
  localparam logic [7:0] VOLT_LOW_MASK = 8'hf8;
  localparam logic [7:0] VOLT_LOW_RESET = 8'h00;
  // Weights of the three lowest value bits, in millivolts.
  localparam int VOLT_BIT5_MV = 32;
  localparam int VOLT_BIT4_MV = 16;
  localparam int VOLT_BIT3_MV = 8;
  // Status high byte field positions.
  localparam int ST_INPUT_PRESENT = 7;
  localparam int ST_OPT_DONE = 6;
  localparam int ST_ASSIST = 5;
  localparam int ST_VIN_REG = 4;
  localparam int ST_IIN_REG = 3;
  localparam int ST_FAST = 2;
  localparam int ST_PRE = 1;
  localparam int ST_REVERSE = 0;
  // Status low byte fault positions.
  localparam int FT_INPUT_OV = 7;
  localparam int FT_BATT_OC = 6;
  localparam int FT_INPUT_OC = 5;
  localparam int FT_SYS_OV = 4;
  localparam int FT_SYS_UV = 3;
  localparam int FT_FORCE_OFF = 2;
  localparam int FT_REV_OV = 1;
  localparam int FT_REV_UV = 0;
  // Faults that clear on a host read; the other two clear on a write of 0.
  localparam logic [7:0] FT_READ_CLEAR = 8'he7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Assist control byte fields and reset value.
  localparam int CTL_ASSIST_OFF = 5;
  localparam int CTL_ADAPTER_HOT = 1;
  localparam int CTL_SYSV_HOT = 0;
  localparam logic [7:0] CTL_MASK = 8'h23;
  localparam logic [7:0] CTL_RESET = 8'h02;
  // Processor-hot status byte: assist-exit flag position.
  localparam int HOT_EXIT = 0;
  // Serial port states.
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_REG, I2C_ACK_REG,
    I2C_WDATA, I2C_ACK_W, I2C_RDATA, I2C_RACK
  } csv_i2c_state_t;
endpackage : csv_pkg

/* File: hdl/csv_regs.sv */
// Behaviour
// RL1: Low value bits weigh 32, 16, 8 mV.
// RL2: Bits 2..0 reserved, reset zero, writes ignored.
// RL3: Input-present follows the input-in-range level.
// RL4: Charger-ok never set without input-present.
// RL5: Listed faults pull charger-ok low.
// RL6: Optimizer-done bit reports routine completion.
// RL7: Assist bit 5; entry only on host command.
// RL8: Assist leaves on command or any fault.
// RL9: Auto exit sets flag, holds processor-hot low.
// RL10: Assist command is pin high and bit clear.
// RL11: Assist entry disables loops, swaps hot triggers.
// RL12: Assist exit re-enables loops and limit pin.
// RL13: Bit 4 reports voltage regulation either direction.
// RL14: Bit 3 reports forward input-current regulation.
// RL15: Bit 2 reports fast charge.
// RL16: Bit 1 reports pre-charge.
// RL17: Bit 0 reports reverse output mode.
// RL18: Read-only faults latch until host read.
// RL19: System-overvoltage latch holds converter off.
// RL20: Status bytes at 0x20 and 0x21, reset zero.
`timescale 1ns/1ps
`default_nettype none
module csv_regs
  import csv_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h09 // Serial address; arbitrary value.
) (
  input wire logic clk_sys, // System clock, 50 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; all state holds while low.
  input wire logic sclIn, // Serial clock pin level.
  input wire logic sdaIn, // Serial data pin level.
  output logic sdaOut, // Serial data drive value, always low.
  output logic sdaOe, // Serial data drive enable, high pulls low.
  input wire logic reverseAssistPin, // Reverse/assist pin level.
  input wire logic vbusInRange, // Input bus within its valid range.
  input wire logic optimizerComplete, // Optimizer routine finished.
  input wire logic vinRegulating, // Input-voltage loop active, forward.
  input wire logic voutRegulating, // Output-voltage loop active, reverse.
  input wire logic iinRegulating, // Input-current loop active.
  input wire logic fastCharging, // Charger in fast charge.
  input wire logic precharging, // Charger in pre-charge.
  input wire logic reverseOutputActive, // Charger in reverse output mode.
  input wire logic [7:0] faultActive, // Fault levels, low-byte layout.
  input wire logic thermalShutdown, // Thermal shutdown level.
  input wire logic batteryOvervoltage, // Battery overvoltage level.
  output logic [7:0] chargeVoltageLow, // Stored charge-voltage low byte.
  output logic chargerOk, // Charger-ok indication.
  output logic converterEnable, // Converter allowed to run.
  output logic processorHotN, // Processor-hot output, active low.
  output logic inputVoltageLoopEn, // Input-voltage loop enable.
  output logic inputCurrentLoopEn, // Input-current loop enable.
  output logic criticalCurrentDetectEn, // Critical-current detect enable.
  output logic currentLimitPinEn, // Current-limit pin function enable.
  output logic adapterOkHotTrigger, // Adapter-ok hot trigger enable.
  output logic systemVoltageHotTrigger // System-voltage hot trigger enable.
);

  // A zero address would answer the general call, which we do not serve.
  if (DEV_ADDR == 7'h00) begin : g_addr_check
    $error("csv_regs: DEV_ADDR must not be zero");
  end

  logic [1:0] sclSync_q; // Serial clock synchroniser chain.
  logic [1:0] sdaSync_q; // Serial data synchroniser chain.
  logic [1:0] pinSync_q; // Assist pin synchroniser chain.
  logic sclPrev_q; // Previous synchronised clock, for edges.
  logic sdaPrev_q; // Previous synchronised data, for edges.
  csv_i2c_state_t state_q; // Serial port state.
  logic [3:0] bitCnt_q; // Bits shifted in the current byte.
  logic [7:0] shift_q; // Receive shift register.
  logic [7:0] txShift_q; // Transmit shift register.
  logic [7:0] txSnap_q; // Byte last loaded for transmit.
  logic [7:0] ptr_q; // Register pointer.
  logic readDir_q; // Current transfer is a read.
  logic hostAck_q; // Host acknowledged the last read byte.
  logic drive_q; // Pull serial data low.
  logic wrStb_q; // One-cycle register write strobe.
  logic [7:0] wrAddr_q; // Address of the strobed write.
  logic [7:0] wrData_q; // Data of the strobed write.
  logic rdStb_q; // One-cycle strobe: a byte was sent to the host.
  logic [7:0] rdAddr_q; // Address of the byte just sent.
  logic [7:0] rdData_q; // Value of the byte just sent.
  logic [7:0] voltLow_q; // Charge-voltage low byte.
  logic [7:0] statHigh_q; // Status high byte.
  logic [7:0] faults_q; // Latched faults, status low byte.
  logic [7:0] ctl_q; // Assist control byte.
  logic assist_q; // Assist mode active.
  logic cmdPrev_q; // Assist command one cycle ago.
  logic exitFlag_q; // Assist mode left on its own.
  logic chgOk_q; // Registered charger-ok.
  logic [3:0] loopEn_q; // Loop enables: vin, iin, crit, limit pin.

  logic sclS; // Synchronised serial clock.
  logic sdaS; // Synchronised serial data.
  logic sclRise; // Serial clock rising edge.
  logic sclFall; // Serial clock falling edge.
  logic startCond; // Start or repeated start seen.
  logic stopCond; // Stop seen.
  logic assistCmd; // Host asks for assist mode.
  logic faultAny; // Any fault is active this cycle.
  logic assist_d; // Next assist state.
  logic [7:0] rdByte; // Byte that the pointer addresses now.

  // Read decode; unmapped addresses read as zero.
  function automatic logic [7:0] readByte(input logic [7:0] a);
    unique case (a)
      ADDR_VOLT_LOW: readByte = voltLow_q & VOLT_LOW_MASK; // see RL2
      ADDR_STAT_LOW: readByte = faults_q; // see RL20
      ADDR_STAT_HIGH: readByte = statHigh_q; // see RL20
      ADDR_HOT_STAT: readByte = {7'h00, exitFlag_q};
      ADDR_ASSIST_CTRL: readByte = ctl_q & CTL_MASK;
      default: readByte = 8'h00;
    endcase
  endfunction : readByte

  assign rdByte = readByte(ptr_q);
  assign sclS = sclSync_q[1];
  assign sdaS = sdaSync_q[1];
  assign sclRise = sclS & ~sclPrev_q;
  assign sclFall = ~sclS & sclPrev_q;
  assign startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopCond = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  assign assistCmd = pinSync_q[1] & ~ctl_q[CTL_ASSIST_OFF]; // see RL10
  assign faultAny = (|faultActive) | thermalShutdown | batteryOvervoltage;

  // Pins come from outside the clock domain, so two flops each.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      pinSync_q <= 2'h0;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else if (ce) begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      pinSync_q <= {pinSync_q[0], reverseAssistPin};
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  // Serial slave: address, pointer, then auto-incrementing data bytes.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= I2C_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      txShift_q <= 8'h00;
      txSnap_q <= 8'h00;
      ptr_q <= 8'h00;
      readDir_q <= 1'b0;
      hostAck_q <= 1'b0;
      drive_q <= 1'b0;
      wrStb_q <= 1'b0;
      wrAddr_q <= 8'h00;
      wrData_q <= 8'h00;
      rdStb_q <= 1'b0;
      rdAddr_q <= 8'h00;
      rdData_q <= 8'h00;
    end else if (ce) begin
      wrStb_q <= 1'b0;
      rdStb_q <= 1'b0;
      if (startCond) begin
        // A start always restarts address reception.
        state_q <= I2C_ADDR;
        bitCnt_q <= 4'h0;
        drive_q <= 1'b0;
      end else if (stopCond) begin
        state_q <= I2C_IDLE;
        drive_q <= 1'b0;
      end else if (sclRise) begin
        // Data is sampled while the clock is high.
        if (state_q == I2C_RACK) begin
          hostAck_q <= ~sdaS;
        end else if (state_q inside {I2C_ADDR, I2C_REG, I2C_WDATA}) begin
          shift_q <= {shift_q[6:0], sdaS};
          bitCnt_q <= bitCnt_q + 4'h1;
        end
      end else if (sclFall) begin
        // Our drive changes only while the clock is low.
        unique case (state_q)
          I2C_IDLE: begin
            drive_q <= 1'b0;
          end
          I2C_ADDR: begin
            if (bitCnt_q == 4'h8) begin
              if (shift_q[7:1] == DEV_ADDR) begin
                state_q <= I2C_ACK_ADDR;
                readDir_q <= shift_q[0];
                drive_q <= 1'b1;
              end else begin
                // Another device is addressed; stay off the bus.
                state_q <= I2C_IDLE;
              end
            end
          end
          I2C_ACK_ADDR: begin
            bitCnt_q <= 4'h0;
            if (readDir_q) begin
              state_q <= I2C_RDATA;
              txShift_q <= rdByte;
              txSnap_q <= rdByte;
              drive_q <= ~rdByte[7];
            end else begin
              state_q <= I2C_REG;
              drive_q <= 1'b0;
            end
          end
          I2C_REG: begin
            if (bitCnt_q == 4'h8) begin
              ptr_q <= shift_q;
              state_q <= I2C_ACK_REG;
              drive_q <= 1'b1;
            end
          end
          I2C_ACK_REG, I2C_ACK_W: begin
            if (state_q == I2C_ACK_W) begin
              ptr_q <= ptr_q + 8'h01;
            end
            state_q <= I2C_WDATA;
            bitCnt_q <= 4'h0;
            drive_q <= 1'b0;
          end
          I2C_WDATA: begin
            if (bitCnt_q == 4'h8) begin
              wrStb_q <= 1'b1;
              wrAddr_q <= ptr_q;
              wrData_q <= shift_q;
              state_q <= I2C_ACK_W;
              drive_q <= 1'b1;
            end
          end
          I2C_RDATA: begin
            if (bitCnt_q == 4'h7) begin
              // Byte is out: release for the host acknowledge.
              state_q <= I2C_RACK;
              drive_q <= 1'b0;
              rdStb_q <= 1'b1;
              rdAddr_q <= ptr_q;
              rdData_q <= txSnap_q;
              ptr_q <= ptr_q + 8'h01;
            end else begin
              txShift_q <= {txShift_q[6:0], 1'b0};
              drive_q <= ~txShift_q[6];
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
          I2C_RACK: begin
            bitCnt_q <= 4'h0;
            if (hostAck_q) begin
              state_q <= I2C_RDATA;
              txShift_q <= rdByte;
              txSnap_q <= rdByte;
              drive_q <= ~rdByte[7];
            end else begin
              state_q <= I2C_IDLE;
              drive_q <= 1'b0;
            end
          end
          default: begin
            state_q <= I2C_IDLE;
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Charge-voltage low byte; reserved bits never store a one.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      voltLow_q <= VOLT_LOW_RESET; // see RL2
    end else if (ce && wrStb_q && wrAddr_q == ADDR_VOLT_LOW) begin
      voltLow_q <= wrData_q & VOLT_LOW_MASK; // see RL1 RL2
    end
  end

  // Live status high byte, refreshed every cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      statHigh_q <= STATUS_RESET; // see RL20
    end else if (ce) begin
      statHigh_q[ST_INPUT_PRESENT] <= vbusInRange; // see RL3
      statHigh_q[ST_OPT_DONE] <= optimizerComplete; // see RL6
      statHigh_q[ST_ASSIST] <= assist_q; // see RL7
      // Forward mode shows input voltage, reverse mode output voltage.
      statHigh_q[ST_VIN_REG] <= reverseOutputActive ? voutRegulating
                                                    : vinRegulating; // see RL13
      statHigh_q[ST_IIN_REG] <= ~reverseOutputActive & iinRegulating; // see RL14
      statHigh_q[ST_FAST] <= fastCharging; // see RL15
      statHigh_q[ST_PRE] <= precharging; // see RL16
      statHigh_q[ST_REVERSE] <= reverseOutputActive; // see RL17
    end
  end

  // Fault latches. A read clears only bits that were actually sent, so an
  // event arriving after the byte was loaded is kept; set wins over clear.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      faults_q <= STATUS_RESET;
    end else if (ce) begin
      logic [7:0] clr;
      clr = 8'h00;
      if (rdStb_q && rdAddr_q == ADDR_STAT_LOW) begin
        clr = rdData_q & FT_READ_CLEAR; // see RL18
      end
      if (wrStb_q && wrAddr_q == ADDR_STAT_LOW) begin
        clr[FT_SYS_OV] = ~wrData_q[FT_SYS_OV]; // see RL19
        clr[FT_SYS_UV] = ~wrData_q[FT_SYS_UV];
      end
      if (!vbusInRange) begin
        clr[FT_SYS_OV] = 1'b1; // see RL19
      end
      faults_q <= (faults_q & ~clr) | faultActive; // see RL18
    end
  end

  // Charger-ok needs input present and none of the blocking faults.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chgOk_q <= 1'b0;
    end else if (ce) begin
      chgOk_q <= vbusInRange & // see RL4
                 ~(faultActive[FT_FORCE_OFF] | faultActive[FT_INPUT_OC] |
                   thermalShutdown | faults_q[FT_SYS_OV] |
                   faults_q[FT_SYS_UV] | batteryOvervoltage); // see RL5
    end
  end

  // Assist mode enters only on a fresh command edge, so after a fault exit
  // it stays out until the host withdraws and reissues the command.
  always_comb begin
    assist_d = assist_q;
    if (assist_q) begin
      if (faultAny || !assistCmd) begin
        assist_d = 1'b0; // see RL8
      end
    end else if (assistCmd && !cmdPrev_q && !faultAny) begin
      assist_d = 1'b1; // see RL7
    end
  end

  // Assist state, exit flag and the edge effects on loops and triggers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      assist_q <= 1'b0;
      cmdPrev_q <= 1'b0;
      exitFlag_q <= 1'b0;
      ctl_q <= CTL_RESET;
      loopEn_q <= 4'hf;
    end else if (ce) begin
      assist_q <= assist_d;
      cmdPrev_q <= assistCmd;
      if (wrStb_q && wrAddr_q == ADDR_ASSIST_CTRL) begin
        ctl_q <= wrData_q & CTL_MASK;
      end
      if (assist_q && faultAny) begin
        exitFlag_q <= 1'b1; // see RL9
      end else if (wrStb_q && wrAddr_q == ADDR_HOT_STAT &&
                   !wrData_q[HOT_EXIT]) begin
        exitFlag_q <= 1'b0;
      end
      if (assist_d && !assist_q) begin
        // Hardware edits of the trigger bits win over a host write.
        loopEn_q <= 4'h0; // see RL11
        ctl_q[CTL_ADAPTER_HOT] <= 1'b0; // see RL11
        ctl_q[CTL_SYSV_HOT] <= 1'b1; // see RL11
      end else if (!assist_d && assist_q) begin
        loopEn_q <= 4'hf; // see RL12
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = drive_q;
  assign chargeVoltageLow = voltLow_q;
  assign chargerOk = chgOk_q;
  assign converterEnable = ~faults_q[FT_SYS_OV]; // see RL19
  assign processorHotN = ~exitFlag_q; // see RL9
  assign inputVoltageLoopEn = loopEn_q[3];
  assign inputCurrentLoopEn = loopEn_q[2];
  assign criticalCurrentDetectEn = loopEn_q[1];
  assign currentLimitPinEn = loopEn_q[0];
  assign adapterOkHotTrigger = ctl_q[CTL_ADAPTER_HOT];
  assign systemVoltageHotTrigger = ctl_q[CTL_SYSV_HOT];

endmodule : csv_regs
`default_nettype wire

/* File: verification/csv_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the register block's pins for interlock and timing slips.
module csv_regs_monitor
  import csv_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic sclIn, // Serial clock level.
  input wire logic sdaOe, // Device pulls data low.
  input wire logic reverseAssistPin, // Assist command pin.
  input wire logic vbusInRange, // Input present level.
  input wire logic [7:0] faultActive, // Fault levels.
  input wire logic thermalShutdown, // Thermal fault level.
  input wire logic batteryOvervoltage, // Battery fault level.
  input wire logic [7:0] chargeVoltageLow, // Stored voltage byte.
  input wire logic chargerOk, // Charger-ok output.
  input wire logic converterEnable, // Converter run enable.
  input wire logic processorHotN, // Processor-hot output.
  input wire logic inputVoltageLoopEn, // Loop enable.
  input wire logic inputCurrentLoopEn, // Loop enable.
  input wire logic criticalCurrentDetectEn, // Detect enable.
  input wire logic currentLimitPinEn, // Limit pin enable.
  input wire logic adapterOkHotTrigger, // Hot trigger enable.
  input wire logic systemVoltageHotTrigger // Hot trigger enable.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Any fault level that must end assist mode.
  sequence s_fault;
    (|faultActive) || thermalShutdown || batteryOvervoltage;
  endsequence
  // Assist entry shows as the loop enables dropping together.
  sequence s_enter;
    $fell(inputVoltageLoopEn);
  endsequence
  volt_rsvd_a: assert property (chargeVoltageLow[2:0] == 3'h0)
    else $error("Reserved voltage bits are set.");
  ok_input_a: assert property (chargerOk |-> $past(vbusInRange))
    else $error("Charger ok without input present.");
  ok_fault_a: assert property ($past(faultActive[FT_FORCE_OFF] ||
    faultActive[FT_INPUT_OC] || thermalShutdown || batteryOvervoltage)
    |-> !chargerOk) else $error("Charger ok during a fault.");
  conv_sysov_a: assert property (faultActive[FT_SYS_OV]
    |-> ##[1:2] !converterEnable) else $error("Converter left on.");
  // The flag must show soon, since the loops are already back on.
  hot_exit_a: assert property ((!inputVoltageLoopEn ##0 s_fault)
    |-> ##[1:3] !processorHotN) else $error("No processor-hot on exit.");
  loops_same_a: assert property ({inputCurrentLoopEn,
    criticalCurrentDetectEn, currentLimitPinEn} == {3{inputVoltageLoopEn}})
    else $error("Loop enables disagree.");
  trig_swap_a: assert property (s_enter |->
    !adapterOkHotTrigger && systemVoltageHotTrigger)
    else $error("Hot triggers not swapped on entry.");
  entry_pin_a: assert property (s_enter |-> reverseAssistPin)
    else $error("Assist entered without the pin.");
  ack_edge_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("Data drive changed while clock high.");
endmodule : csv_regs_monitor
bind csv_regs csv_regs_monitor u_csv_regs_monitor (.*);
`default_nettype wire

/* File: verification/csv_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host controller that reaches the block over the two-wire serial bus.
module csv_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h09 // Device address; arbitrary value.
) (
  input wire logic clk_sys, // System clock, paces the bus.
  input wire logic sda, // Resolved data wire level.
  output logic scl, // Serial clock, driven by the host.
  output logic sdaLow // High while the host pulls data low.
);
  int nacks = 0; // Missing acknowledges seen so far.
  // The bus idles high on both wires.
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Steps past the edge so that changes never race the sampling.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // Ten-clock half periods leave the device's synchroniser ample margin.
  task automatic putBit(input logic b);
    sdaLow = !b;
    tick(10);
    scl = 1'b1;
    tick(10);
    scl = 1'b0;
  endtask : putBit
  // Released data floats high, so a silent device reads as ones.
  task automatic getBit(output logic b);
    sdaLow = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(5);
    b = sda;
    tick(5);
    scl = 1'b0;
  endtask : getBit
  // Start (stp low) or stop (stp high): data moves while the clock is high.
  task automatic cond(input logic stp);
    sdaLow = stp;
    tick(10);
    scl = 1'b1;
    tick(10);
    sdaLow = !stp;
    tick(10);
    if (!stp) scl = 1'b0;
  endtask : cond
  // Sends a byte, high bit first, and counts a missing acknowledge.
  task automatic putByte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) putBit(d[i]);
    getBit(a);
    if (a !== 1'b0) nacks++;
  endtask : putByte
  // Writes one register byte.
  task automatic wrReg(input logic [7:0] r, input logic [7:0] d);
    cond(1'b0);
    putByte({DEV_ADDR, 1'b0});
    putByte(r);
    putByte(d);
    cond(1'b1);
  endtask : wrReg
  // Reads one byte after a repeated start and ends with a refusal.
  task automatic rdReg(input logic [7:0] r, output logic [7:0] d);
    cond(1'b0);
    putByte({DEV_ADDR, 1'b0});
    putByte(r);
    cond(1'b0);
    putByte({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) getBit(d[i]);
    putBit(1'b1);
    cond(1'b1);
  endtask : rdReg
endmodule : csv_host_model
`default_nettype wire

/* File: verification/charger_status_and_voltage_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the charger status and voltage registers.
module charger_status_and_voltage_regs_test;
  import csv_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1; // Clock, reset, enable.
  logic reverseAssistPin = 1'b0, vbusInRange = 1'b0; // Level inputs.
  logic optimizerComplete = 1'b0, vinRegulating = 1'b0; // Status levels.
  logic voutRegulating = 1'b0, iinRegulating = 1'b0; // Status levels.
  logic fastCharging = 1'b0, precharging = 1'b0; // Status levels.
  logic reverseOutputActive = 1'b0, thermalShutdown = 1'b0; // Levels.
  logic batteryOvervoltage = 1'b0; // Battery fault level.
  logic [7:0] faultActive = 8'h00; // Fault levels.
  logic sclIn, sdaOut, sdaOe, hostLow, chargerOk, converterEnable; // Pins.
  logic processorHotN, inputVoltageLoopEn, inputCurrentLoopEn; // Pins.
  logic criticalCurrentDetectEn, currentLimitPinEn; // Loop enables.
  logic adapterOkHotTrigger, systemVoltageHotTrigger; // Trigger enables.
  logic [7:0] chargeVoltageLow; // Stored voltage byte.
  wire logic sdaIn; // Resolved open-drain data wire.
  wire logic [7:0] pins; // Control pins packed for one compare.
  int errors = 0, num_checks = 0; // Mismatch and compare counts.
  integer seed = 32'haa912b7f; // Fixed seed for a repeatable run.
  // The wire has a pull-up, so it is low only while someone pulls it.
  assign sdaIn = !(sdaOe || hostLow);
  assign pins = {inputVoltageLoopEn, inputCurrentLoopEn,
    criticalCurrentDetectEn, currentLimitPinEn, processorHotN,
    converterEnable, adapterOkHotTrigger, chargerOk};
  always #10 clk_sys = !clk_sys;
  csv_regs u_csv_regs (.*);
  csv_host_model u_csv_host_model (.clk_sys, .sda(sdaIn), .scl(sclIn),
    .sdaLow(hostLow));
  // Inputs always move one nanosecond after the edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rdChk(input string what, input logic [7:0] r,
    input logic [7:0] exp);
    logic [7:0] d;
    u_csv_host_model.rdReg(r, d);
    check(what, exp, d);
  endtask : rdChk
  task automatic test_done();
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // A hung bus would stall the host forever, so cap the run.
  initial begin
    repeat (80000) @(posedge clk_sys);
    errors++;
    test_done();
  end
  initial begin
    logic [7:0] d;
    int mv, hi;
    step(12);
    rst = 1'b0;
    step(3);
    check("reset pins", 8'hfe, pins);
    rdChk("volt reset", ADDR_VOLT_LOW, VOLT_LOW_RESET);
    rdChk("low reset", ADDR_STAT_LOW, 8'h00);
    rdChk("high reset", ADDR_STAT_HIGH, 8'h00);
    rdChk("ctl reset", ADDR_ASSIST_CTRL, CTL_RESET);
    u_csv_host_model.wrReg(8'h10, 8'h5a);
    rdChk("unmapped", 8'h10, 8'h00);
    u_csv_host_model.wrReg(ADDR_STAT_HIGH, 8'hff);
    rdChk("high ro", ADDR_STAT_HIGH, 8'h00);
    // Random voltage bytes: reserved bits must never stick.
    repeat (4) begin
      d = 8'($random(seed));
      mv = d[5] * 32 + d[4] * 16 + d[3] * 8;
      u_csv_host_model.wrReg(ADDR_VOLT_LOW, d);
      rdChk("volt read", ADDR_VOLT_LOW, d & 8'hf8);
      check("volt mv", 8'(mv), 8'(chargeVoltageLow[5:3] * 8));
    end
    // Random status levels against the integer model.
    repeat (6) begin
      {vbusInRange, optimizerComplete, vinRegulating, voutRegulating,
        iinRegulating, fastCharging, precharging, reverseOutputActive} =
        8'($random(seed));
      step(2);
      hi = {vbusInRange, optimizerComplete, 1'b0,
        reverseOutputActive ? voutRegulating : vinRegulating,
        iinRegulating && !reverseOutputActive, fastCharging, precharging,
        reverseOutputActive};
      rdChk("status", ADDR_STAT_HIGH, 8'(hi));
      check("ok", {7'h0, vbusInRange}, {7'h0, chargerOk});
    end
    {optimizerComplete, vinRegulating, voutRegulating, iinRegulating,
      fastCharging, precharging, reverseOutputActive} = 7'h00;
    vbusInRange = 1'b1;
    // Fault pulses latch, then clear on the first read.
    repeat (3) begin
      hi = $random(seed);
      d = 8'(hi) & 8'he7 | 8'h01;
      faultActive = d;
      thermalShutdown = hi[8];
      batteryOvervoltage = hi[9];
      step(3);
      check("ok fault", {7'h0, !(d[2] || d[5] || hi[8] || hi[9])},
        {7'h0, chargerOk});
      faultActive = 8'h00;
      {thermalShutdown, batteryOvervoltage} = 2'b00;
      step(2);
      rdChk("fault latch", ADDR_STAT_LOW, d);
      rdChk("fault clear", ADDR_STAT_LOW, 8'h00);
    end
    faultActive = 8'h18;
    step(3);
    check("conv off", 8'h00, {7'h0, converterEnable});
    faultActive = 8'h00;
    step(3);
    rdChk("ov latch", ADDR_STAT_LOW, 8'h18);
    u_csv_host_model.wrReg(ADDR_STAT_LOW, 8'hff);
    rdChk("ov kept", ADDR_STAT_LOW, 8'h18);
    u_csv_host_model.wrReg(ADDR_STAT_LOW, 8'h00);
    rdChk("ov clear", ADDR_STAT_LOW, 8'h00);
    check("conv on", 8'h01, {7'h0, converterEnable});
    // Assist entry and exit by pin, by control bit and by fault.
    reverseAssistPin = 1'b1;
    step(8);
    check("enter", 8'h0d, pins);
    rdChk("assist bit", ADDR_STAT_HIGH, 8'ha0);
    reverseAssistPin = 1'b0;
    step(8);
    check("pin exit", 8'hfd, pins);
    reverseAssistPin = 1'b1;
    step(8);
    u_csv_host_model.wrReg(ADDR_ASSIST_CTRL, 8'h21);
    step(4);
    check("bit exit", 8'hfd, pins);
    u_csv_host_model.wrReg(ADDR_ASSIST_CTRL, 8'h01);
    step(4);
    check("reenter", 8'h0d, pins);
    faultActive = 8'h01;
    step(3);
    faultActive = 8'h00;
    reverseAssistPin = 1'b0;
    step(20);
    check("fault exit", 8'hf5, pins);
    rdChk("exit flag", ADDR_HOT_STAT, 8'h01);
    u_csv_host_model.wrReg(ADDR_HOT_STAT, 8'h00);
    step(3);
    check("flag clear", 8'hfd, pins);
    rdChk("uv latch", ADDR_STAT_LOW, 8'h01);
    check("acks", 8'h00, 8'(u_csv_host_model.nacks));
    test_done();
  end
endmodule : charger_status_and_voltage_regs_test
`default_nettype wire
